//--- rtl/dual_timer_pwm_counter.sv
// top of the dual timer and pwm block with its register file
//
// The strobed register port was chosen for this implementation.
module dual_timer_pwm_counter (
    input wire logic clk,
    input wire logic reset,
    input wire logic [31:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdData_q,
    output logic [1:0] pwmOut,
    output logic [1:0] irqOut_q
);

    localparam int N = timer_pkg::COUNTERS;

    logic [31:0] reloadLow_q [N];
    logic [31:0] reloadHigh_q [N];
    logic [timer_pkg::CTRL_WIDTH-1:0] ctrl_q [N];
    logic [31:0] liveCount [N];

    logic [N-1:0] hitLow;
    logic [N-1:0] hitLive;
    logic [N-1:0] hitCtrl;
    logic [N-1:0] hitClear;
    logic [N-1:0] hitStatus;
    logic [N-1:0] hitHigh;

    logic [N-1:0] ctrlEn;
    logic [N-1:0] ctrlUser;
    logic [N-1:0] ctrlMask;
    logic [N-1:0] ctrlPwm;

    logic [N-1:0] wrapEvent;
    logic [N-1:0] clearReq;
    logic [N-1:0] rawFlag;
    logic [N-1:0] maskedFlag;

    logic hitAllMasked;
    logic hitAllClear;
    logic hitAllRaw;
    logic hitVersion;
    logic allClear;
    logic [31:0] readMux;

    // shared register decode
    assign hitAllMasked = (addr == timer_pkg::ADDR_ALL_MASKED);
    assign hitAllClear = (addr == timer_pkg::ADDR_ALL_CLEAR);
    assign hitAllRaw = (addr == timer_pkg::ADDR_ALL_RAW);
    assign hitVersion = (addr == timer_pkg::ADDR_VERSION);
    // a read of the combined clear register drops every flag at once
    assign allClear = rdStrobe & hitAllClear;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_chan
            localparam logic [31:0] LOW_ADDR = (i == 0) ?
                timer_pkg::ADDR_C1_RELOAD_LOW : timer_pkg::ADDR_C2_RELOAD_LOW;
            localparam logic [31:0] LIVE_ADDR = (i == 0) ?
                timer_pkg::ADDR_C1_LIVE : timer_pkg::ADDR_C2_LIVE;
            localparam logic [31:0] CTRL_ADDR = (i == 0) ?
                timer_pkg::ADDR_C1_CTRL : timer_pkg::ADDR_C2_CTRL;
            localparam logic [31:0] CLEAR_ADDR = (i == 0) ?
                timer_pkg::ADDR_C1_CLEAR : timer_pkg::ADDR_C2_CLEAR;
            localparam logic [31:0] STATUS_ADDR = (i == 0) ?
                timer_pkg::ADDR_C1_STATUS : timer_pkg::ADDR_C2_STATUS;
            localparam logic [31:0] HIGH_ADDR = (i == 0) ?
                timer_pkg::ADDR_C1_RELOAD_HIGH : timer_pkg::ADDR_C2_RELOAD_HIGH;

            // per-counter decode
            assign hitLow[i] = (addr == LOW_ADDR);
            assign hitLive[i] = (addr == LIVE_ADDR);
            assign hitCtrl[i] = (addr == CTRL_ADDR);
            assign hitClear[i] = (addr == CLEAR_ADDR);
            assign hitStatus[i] = (addr == STATUS_ADDR);
            assign hitHigh[i] = (addr == HIGH_ADDR);

            // control fields
            assign ctrlEn[i] = ctrl_q[i][timer_pkg::CTRL_ENABLE_BIT];
            assign ctrlUser[i] = ctrl_q[i][timer_pkg::CTRL_USER_MODE_BIT];
            assign ctrlMask[i] = ctrl_q[i][timer_pkg::CTRL_MASK_BIT];
            assign ctrlPwm[i] = ctrl_q[i][timer_pkg::CTRL_PWM_BIT];

            // own clear read or the combined one
            assign clearReq[i] = (rdStrobe & hitClear[i]) | allClear;
            // mask only hides the flag, the raw flag keeps its state
            assign maskedFlag[i] = rawFlag[i] & ~ctrlMask[i];

            // software writable registers; reserved control bits drop
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    reloadLow_q[i] <= timer_pkg::RELOAD_RESET;
                    reloadHigh_q[i] <= timer_pkg::RELOAD_RESET;
                    ctrl_q[i] <= timer_pkg::CTRL_RESET;
                end
                else if (wrStrobe)
                begin
                    if (hitLow[i])
                        reloadLow_q[i] <= wrData;
                    if (hitHigh[i])
                        reloadHigh_q[i] <= wrData;
                    if (hitCtrl[i])
                        ctrl_q[i] <= wrData[timer_pkg::CTRL_WIDTH-1:0];
                end
            end

            counter_channel u_channel (
                .clk(clk),
                .reset(reset),
                .enable(ctrlEn[i]),
                .userMode(ctrlUser[i]),
                .pwmMode(ctrlPwm[i]),
                .reloadLow(reloadLow_q[i]),
                .reloadHigh(reloadHigh_q[i]),
                .count_q(liveCount[i]),
                .wrapEvent(wrapEvent[i]),
                .pwmLevel_q(pwmOut[i])
            );

            // every wrap sets the flag, so pwm flags both edges
            sticky_flag u_flag (
                .clk(clk),
                .reset(reset),
                .set(wrapEvent[i]),
                .clear(clearReq[i]),
                .flag_q(rawFlag[i])
            );
        end
    endgenerate

    // read selection; clear registers and unmapped addresses read zero
    assign readMux =
        hitLow[0] ? reloadLow_q[0] :
        hitLive[0] ? liveCount[0] :
        hitCtrl[0] ? {28'h0000000, ctrl_q[0]} :
        hitStatus[0] ? {31'h00000000, maskedFlag[0]} :
        hitHigh[0] ? reloadHigh_q[0] :
        hitLow[1] ? reloadLow_q[1] :
        hitLive[1] ? liveCount[1] :
        hitCtrl[1] ? {28'h0000000, ctrl_q[1]} :
        hitStatus[1] ? {31'h00000000, maskedFlag[1]} :
        hitHigh[1] ? reloadHigh_q[1] :
        hitAllMasked ? {30'h00000000, maskedFlag} :
        hitAllRaw ? {30'h00000000, rawFlag} :
        hitVersion ? timer_pkg::VERSION_WORD :
        timer_pkg::READ_IDLE;

    // read data only in the cycle after the strobe; the live value is
    // sampled in the strobe cycle, so no read can ever stall the master
    always_ff @(posedge clk)
    begin
        if (reset)
            rdData_q <= timer_pkg::READ_IDLE;
        else if (rdStrobe)
            rdData_q <= readMux;
        else
            rdData_q <= timer_pkg::READ_IDLE;
    end

    // interrupt lines lag the flag by one clock to come from a flop
    always_ff @(posedge clk)
    begin
        if (reset)
            irqOut_q <= 2'h0;
        else
            irqOut_q <= maskedFlag;
    end

    // checks; counter one and the combined clear first, then counter two mixed with more counter one and shared checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    chk_enable_load: assert property (
        $rose(ctrlEn[0]) |=> liveCount[0] == $past(reloadLow_q[0]))
        else $error("enable did not load the low reload value");

    chk_user_alternate: assert property (
        ctrlEn[0] && $past(ctrlEn[0]) && ctrlUser[0] && liveCount[0] == 32'h0
        |=> liveCount[0] == $past(reloadLow_q[0])
            || liveCount[0] == $past(reloadHigh_q[0]))
        else $error("user mode reload not from a reload register");

    chk_free_reload: assert property (
        ctrlEn[0] && $past(ctrlEn[0]) && !ctrlUser[0] && liveCount[0] == 32'h0
        |=> liveCount[0] == timer_pkg::ALL_ONES)
        else $error("free running wrap did not load all ones");

    chk_decrement: assert property (
        ctrlEn[0] && $past(ctrlEn[0]) && liveCount[0] != 32'h0
        |=> liveCount[0] == $past(liveCount[0]) - 32'h1)
        else $error("enabled counter did not decrement by one");

    chk_wrap_flag: assert property (
        $past(liveCount[0]) == 32'h0 && $past(ctrlEn[0])
        && $past(ctrlEn[0], 2) |-> rawFlag[0])
        else $error("wrap from zero did not raise the flag");

    chk_timer_idle: assert property (
        !ctrlPwm[0] |=> !pwmOut[0])
        else $error("waveform output active in timer mode");

    chk_pwm_high: assert property (
        $rose(pwmOut[0]) && $past(ctrlPwm[0]) && $past(ctrlEn[0], 2)
        |-> liveCount[0] == $past(reloadHigh_q[0]))
        else $error("high phase did not load the high reload");

    chk_pwm_edges: assert property (
        $changed(pwmOut[0]) && $past(ctrlPwm[0]) && $past(ctrlEn[0])
        && $past(ctrlEn[0], 2) |-> rawFlag[0])
        else $error("waveform edge without interrupt flag");

    chk_live_read: assert property (
        rdStrobe && hitLive[0] |=> rdData_q == $past(liveCount[0]))
        else $error("live value read returned wrong count");

    chk_ctrl_write: assert property (
        wrStrobe && hitCtrl[0] ##1 rdStrobe && hitCtrl[0]
        |=> rdData_q == {28'h0, $past(wrData[3:0], 2)})
        else $error("control register did not read back");

    chk_mask_gate: assert property (
        ctrlMask[0] && $past(ctrlMask[0]) |-> !irqOut_q[0])
        else $error("masked interrupt reached the output");

    chk_disabled_hold: assert property (
        !ctrlEn[0] |=> $stable(liveCount[0]))
        else $error("disabled counter changed value");

    chk_clear_read: assert property (
        rdStrobe && hitClear[0] && !wrapEvent[0]
        |=> !rawFlag[0] && rdData_q == 32'h0)
        else $error("clear read did not clear or read zero");

    chk_status_read: assert property (
        rdStrobe && hitStatus[0]
        |=> rdData_q == {31'h0, $past(rawFlag[0] & ~ctrlMask[0])})
        else $error("status read disagrees with masked flag");

    chk_all_clear: assert property (
        rdStrobe && hitAllClear && !wrapEvent[1] && !wrapEvent[0]
        |=> rawFlag == 2'h0 && rdData_q == 32'h0)
        else $error("combined clear left a flag set");

    chk_flag_sticky: assert property (
        rawFlag[0] && !clearReq[0] |=> rawFlag[0] [*1])
        else $error("raw flag dropped without a clear");

    // counter two shares the channel logic, so a lighter set is enough here
    chk_two_load: assert property (
        $rose(ctrlEn[1]) |=> liveCount[1] == $past(reloadLow_q[1]))
        else $error("counter two enable did not load the low reload");

    chk_two_user_wrap: assert property (
        ctrlEn[1] && $past(ctrlEn[1]) && ctrlUser[1] && liveCount[1] == 32'h0
        |=> liveCount[1] == $past(reloadLow_q[1])
            || liveCount[1] == $past(reloadHigh_q[1]))
        else $error("counter two user reload not from a reload register");

    chk_two_sticky: assert property (
        rawFlag[1] && !clearReq[1] |=> rawFlag[1])
        else $error("counter two flag dropped without a clear");

    chk_two_decrement: assert property (
        ctrlEn[1] && $past(ctrlEn[1]) && liveCount[1] != 32'h0
        |=> liveCount[1] == $past(liveCount[1]) - 32'h1)
        else $error("counter two did not decrement by one");

    chk_two_wrap_flag: assert property (
        $past(liveCount[1]) == 32'h0 && $past(ctrlEn[1])
        && $past(ctrlEn[1], 2) |-> rawFlag[1])
        else $error("counter two wrap did not raise the flag");

    chk_two_idle: assert property (
        !ctrlPwm[1] |=> !pwmOut[1])
        else $error("counter two waveform active in timer mode");

    chk_pwm_start: assert property (
        $rose(ctrlEn[0]) |=> !pwmOut[0])
        else $error("waveform did not start low on enable");

    chk_two_live_read: assert property (
        rdStrobe && hitLive[1] |=> rdData_q == $past(liveCount[1]))
        else $error("counter two live read returned wrong count");

    chk_ctrl_upper: assert property (
        rdStrobe && hitCtrl[0] |=> rdData_q[31:4] == 28'h0)
        else $error("reserved control bits read non-zero");

    chk_two_mask: assert property (
        ctrlMask[1] && $past(ctrlMask[1]) |-> !irqOut_q[1])
        else $error("counter two masked interrupt reached the output");

    chk_two_clear: assert property (
        rdStrobe && hitClear[1] && !wrapEvent[1]
        |=> !rawFlag[1] && rdData_q == 32'h0)
        else $error("counter two clear read did not clear or read zero");

    chk_masked_read: assert property (
        rdStrobe && hitAllMasked
        |=> rdData_q == {30'h0, $past(rawFlag & ~ctrlMask)})
        else $error("combined status read disagrees with masked flags");

    chk_raw_read: assert property (
        rdStrobe && hitAllRaw |=> rdData_q == {30'h0, $past(rawFlag)})
        else $error("raw status read disagrees with the raw flags");

    chk_irq_unmasked: assert property (
        rawFlag[1] && !ctrlMask[1] |=> irqOut_q[1])
        else $error("unmasked flag did not reach the interrupt output");

    cov_user_wrap: cover property (
        ctrlUser[0] && wrapEvent[0] ##1 rawFlag[0]);

    cov_pwm_cycle: cover property (
        $rose(pwmOut[0]) ##[1:1000] $fell(pwmOut[0]));

    cov_clear_flag: cover property (
        rawFlag[0] && rdStrobe && hitClear[0]);

    cov_both_clear: cover property (
        rawFlag == 2'h3 && allClear);

    cov_write_read: cover property (
        wrStrobe && hitCtrl[0] ##1 rdStrobe && hitCtrl[0]);

endmodule : dual_timer_pwm_counter

//--- rtl/timer_pkg.sv
// shared constants of the dual timer and pwm block
package timer_pkg;

    localparam int COUNTERS = 2;
    localparam int CTRL_WIDTH = 4;

    // byte addresses of the register map
    localparam logic [31:0] ADDR_C1_RELOAD_LOW = 32'hb000_0800;
    localparam logic [31:0] ADDR_C1_LIVE = 32'hb000_0804;
    localparam logic [31:0] ADDR_C1_CTRL = 32'hb000_0808;
    localparam logic [31:0] ADDR_C1_CLEAR = 32'hb000_080c;
    localparam logic [31:0] ADDR_C1_STATUS = 32'hb000_0810;
    localparam logic [31:0] ADDR_C2_RELOAD_LOW = 32'hb000_0814;
    localparam logic [31:0] ADDR_C2_LIVE = 32'hb000_0818;
    localparam logic [31:0] ADDR_C2_CTRL = 32'hb000_081c;
    localparam logic [31:0] ADDR_C2_CLEAR = 32'hb000_0820;
    localparam logic [31:0] ADDR_C2_STATUS = 32'hb000_0824;
    localparam logic [31:0] ADDR_ALL_MASKED = 32'hb000_08a0;
    localparam logic [31:0] ADDR_ALL_CLEAR = 32'hb000_08a4;
    localparam logic [31:0] ADDR_ALL_RAW = 32'hb000_08a8;
    localparam logic [31:0] ADDR_VERSION = 32'hb000_08ac;
    localparam logic [31:0] ADDR_C1_RELOAD_HIGH = 32'hb000_08b0;
    localparam logic [31:0] ADDR_C2_RELOAD_HIGH = 32'hb000_08b4;

    // control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_USER_MODE_BIT = 1;
    localparam int CTRL_MASK_BIT = 2;
    localparam int CTRL_PWM_BIT = 3;

    // values after reset and fixed words
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h0;
    localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;
    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
    // version word value is arbitrary
    localparam logic [31:0] VERSION_WORD = 32'h0000_0101;

endpackage : timer_pkg

//--- rtl/sticky_flag.sv
// one interrupt flag that a hardware event sets and a read clears
module sticky_flag (
    input wire logic clk,
    input wire logic reset,
    input wire logic set,
    input wire logic clear,
    output logic flag_q
);

    logic flag_d;

    // set beats clear so an event in the clearing cycle is kept
    assign flag_d = set | (flag_q & ~clear);

    always_ff @(posedge clk)
    begin
        if (reset)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

endmodule : sticky_flag

//--- rtl/counter_channel.sv
// one 32-bit down-counter with its reload policy and pwm phase
module counter_channel (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic userMode,
    input wire logic pwmMode,
    input wire logic [31:0] reloadLow,
    input wire logic [31:0] reloadHigh,
    output logic [31:0] count_q,
    output logic wrapEvent,
    output logic pwmLevel_q
);

    logic running_q;
    logic phaseHigh_q;
    logic phaseHigh_d;
    logic [31:0] count_d;
    logic startUp;
    logic atZero;
    logic [31:0] userReload;
    logic [31:0] wrapReload;

    // first enabled cycle after reset or disable loads the low reload
    assign startUp = enable & ~running_q;
    assign atZero = (count_q == 32'h0000_0000);
    // alternate between the two reloads, current contents used
    assign userReload = phaseHigh_q ? reloadLow : reloadHigh;
    assign wrapReload = userMode ? userReload : timer_pkg::ALL_ONES;
    // the event is the step from zero to the reloaded value
    assign wrapEvent = enable & running_q & atZero;

    // decrement every clock while enabled, freeze while disabled
    assign count_d = startUp ? reloadLow :
        ~enable ? count_q :
        atZero ? wrapReload :
        count_q - 32'h0000_0001;

    // phase toggles only in user mode so free-running never alternates
    assign phaseHigh_d = startUp ? 1'b0 :
        (wrapEvent & userMode) ? ~phaseHigh_q : phaseHigh_q;

    // low phase lasts reload plus one clocks: reload down to zero inclusive
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_q <= timer_pkg::COUNT_RESET;
            running_q <= 1'b0;
            phaseHigh_q <= 1'b0;
            pwmLevel_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            running_q <= enable;
            phaseHigh_q <= phaseHigh_d;
            pwmLevel_q <= pwmMode & phaseHigh_d;
        end
    end

endmodule : counter_channel

//--- test/dual_timer_pwm_counter_bench.sv
// self-checking bench of the dual timer and pwm block
module dual_timer_pwm_counter_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] addr = 32'h0;
    logic [31:0] wrData = 32'h0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [31:0] rdData_q;
    logic [1:0] pwmOut;
    logic [1:0] irqOut_q;
    logic rdPend = 1'b0;
    logic [31:0] expQ[$];
    logic [31:0] addrQ[$];
    int n_fail = 0;
    int checked = 0;
    int seed = 32'h3faf;
    int lowVal;
    int highVal;

    dual_timer_pwm_counter i_dual_timer_pwm_counter (
        .clk(clk),
        .reset(reset),
        .addr(addr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .rdData_q(rdData_q),
        .pwmOut(pwmOut),
        .irqOut_q(irqOut_q)
    );

    // 100 mhz clock
    always #5 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_word

    task automatic cmp_pin(input string what, input logic [1:0] e, input logic [1:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask : cmp_pin

    // one-cycle write; the leading edge keeps strobes from being assigned twice in a step
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr

    // one-cycle read; the expected word is noted for the monitor
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        expQ.push_back(e);
        addrQ.push_back(a);
        @(posedge clk);
        rdStrobe <= 1'b0;
    endtask : rd

    // write then read in the very next cycle, as the bus allows
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b1;
        expQ.push_back(e);
        addrQ.push_back(a);
        @(posedge clk);
        rdStrobe <= 1'b0;
    endtask : wr_rd

    // read data stand only in the cycle after the strobe, so they are taken at that edge
    always @(posedge clk)
    begin
        if (rdPend)
        begin
            if (expQ.size() == 0)
                cmp_word("unexpected read", 32'h0, 32'hxxxx_xxxx);
            else
                cmp_word($sformatf("read %h", addrQ.pop_front()), expQ.pop_front(), rdData_q);
        end
        rdPend <= rdStrobe;
    end

    // pins are looked at mid-cycle, where they have settled
    task automatic pins(input logic [1:0] ePwm, input logic [1:0] eIrq);
        @(negedge clk);
        cmp_pin("pwmOut", ePwm, pwmOut);
        cmp_pin("irqOut_q", eIrq, irqOut_q);
    endtask : pins

    // run is under two hundred cycles; this cuts off a hang
    initial
    begin
        #20000;
        n_fail++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] r;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // reset values of the whole map, then unmapped places
        for (int i = 0; i < 16; i++)
        begin
            r = (i < 10) ? 32'hb000_0800 + 4 * i : 32'hb000_08a0 + 4 * (i - 10);
            rd(r, (r == timer_pkg::ADDR_VERSION) ? timer_pkg::VERSION_WORD : 32'h0);
        end
        rd(32'hb000_0828, 32'h0);
        rd(32'hc000_0800, 32'h0);
        // read-only places ignore writes, control keeps only its low four bits
        r = $random(seed);
        wr(timer_pkg::ADDR_C1_LIVE, r);
        rd(timer_pkg::ADDR_C1_LIVE, 32'h0);
        wr(timer_pkg::ADDR_C2_CTRL, 32'hffff_fff0);
        rd(timer_pkg::ADDR_C2_CTRL, 32'h0);
        wr(timer_pkg::ADDR_C2_RELOAD_HIGH, r);
        rd(timer_pkg::ADDR_C2_RELOAD_HIGH, r);
        wr_rd(timer_pkg::ADDR_C1_CTRL, 32'hffff_fff4, 32'h4);
        // counter one free-running: load, count down, wrap to all ones
        wr(timer_pkg::ADDR_C1_RELOAD_LOW, 32'h3);
        wr(timer_pkg::ADDR_C1_CTRL, 32'h1);
        rd(timer_pkg::ADDR_C1_LIVE, 32'h3);
        repeat (3) @(posedge clk);
        rd(timer_pkg::ADDR_C1_LIVE, 32'hffff_fffe);
        pins(2'b00, 2'b01);
        repeat (2) wr(timer_pkg::ADDR_VERSION, 32'h0);
        rd(timer_pkg::ADDR_C1_STATUS, 32'h1);
        rd(timer_pkg::ADDR_ALL_MASKED, 32'h1);
        rd(timer_pkg::ADDR_C1_CLEAR, 32'h0);
        rd(timer_pkg::ADDR_C1_STATUS, 32'h0);
        rd(timer_pkg::ADDR_ALL_RAW, 32'h0);
        pins(2'b00, 2'b00);
        // counter two user mode, masked: low and high reloads alternate
        wr(timer_pkg::ADDR_C2_RELOAD_LOW, 32'h4);
        wr(timer_pkg::ADDR_C2_RELOAD_HIGH, 32'h2);
        wr(timer_pkg::ADDR_C2_CTRL, 32'h7);
        repeat (5) @(posedge clk);
        rd(timer_pkg::ADDR_C2_LIVE, 32'h2);
        rd(timer_pkg::ADDR_C2_LIVE, 32'h0);
        rd(timer_pkg::ADDR_C2_LIVE, 32'h3);
        rd(timer_pkg::ADDR_C2_STATUS, 32'h0);
        rd(timer_pkg::ADDR_ALL_RAW, 32'h2);
        rd(timer_pkg::ADDR_ALL_MASKED, 32'h0);
        pins(2'b00, 2'b00);
        // unmasking shows the flag that was held all along; the line lags one clock
        wr(timer_pkg::ADDR_C2_CTRL, 32'h3);
        @(posedge clk);
        pins(2'b00, 2'b10);
        wr(timer_pkg::ADDR_C2_CTRL, 32'h6);
        rd(timer_pkg::ADDR_C2_CTRL, 32'h6);
        rd(timer_pkg::ADDR_ALL_CLEAR, 32'h0);
        rd(timer_pkg::ADDR_ALL_RAW, 32'h0);
        // counter one pwm with random phases; user mode is set as pwm demands
        wr(timer_pkg::ADDR_C1_CTRL, 32'h0);
        lowVal = 1 + ($random(seed) & 3);
        highVal = 1 + ($random(seed) & 3);
        wr(timer_pkg::ADDR_C1_RELOAD_LOW, lowVal);
        wr(timer_pkg::ADDR_C1_RELOAD_HIGH, highVal);
        wr(timer_pkg::ADDR_C1_CTRL, 32'hb);
        // the load happens at the edge after the write, so the loop starts there
        @(posedge clk);
        for (int k = 1; k <= 3 * (lowVal + highVal + 2); k++)
        begin
            r = (k - 1) % (lowVal + highVal + 2);
            pins({1'b0, r >= lowVal + 1}, {1'b0, k >= lowVal + 3});
        end
        wr(timer_pkg::ADDR_C1_CTRL, 32'h0);
        rd(timer_pkg::ADDR_C1_CLEAR, 32'h0);
        // the interrupt line follows the cleared flag one clock later
        @(posedge clk);
        pins(2'b00, 2'b00);
        repeat (3) @(posedge clk);
        cmp_word("queue left", 32'h0, expQ.size());
        report_and_stop();
    end

endmodule : dual_timer_pwm_counter_bench
